/* mmw_pkg.sv */
// Package for the monitor mux select and wake input block
// Notes on behaviour
// - Software picks the monitor source by a 5-bit select field that resets to zero, which routes ground.
// - Codes one to six route io supply, temperature, main bandgap, fail-safe bandgap, core buck and second buck.
// - Codes seven to twelve route third buck, pre-regulator, boost, both linear regulators and bias, each over 2.5.
// - Code fourteen routes the battery supply input over 7.5 or 14 as the ratio bit says.
// - Codes fifteen and sixteen route the first and second wake inputs over 7.45 or 13.85 by the ratio bit.
// - Codes seventeen to twenty route analog supply, digital supply, fail-safe digital supply and power sync pin.
// - Any unassigned code behaves as the zero default and routes ground.
// - A wake input above its high threshold starts biasing and reads as one.
// - A wake input below its digital low threshold reads as zero.
// - Biasing stops only when both wake inputs are below the analog low threshold while in Standby.
// - Wake inputs are level based and a new level is accepted only after persisting through the filter time.
// - Filtered wake states are given to the main state machine as transition conditions.
package mmw_pkg;
    localparam int CLK_FREQ_HZ = 10000000;
    localparam int WAKE_FILT_MIN_US = 50;
    localparam int WAKE_FILT_TYP_US = 70;
    localparam int WAKE_FILT_MAX_US = 100;
    // Typical filter time as a count of cycles
    localparam int WAKE_FILT_CYC = WAKE_FILT_TYP_US * (CLK_FREQ_HZ / 1000000);
    localparam int SEL_W = 5;
    localparam int SRC_W = 21;
    localparam logic [4:0] SEL_RST = 5'h00;

    typedef enum logic [1:0] {
        MMW_DIV_1,
        MMW_DIV_2P5,
        MMW_DIV_LO,
        MMW_DIV_HI
    } mmw_div_e;

    typedef struct packed {
        logic [SRC_W-1:0] src_onehot;
        mmw_div_e div;
    } mmw_route_s;

    typedef struct packed {
        logic wake_first;
        logic wake_second;
        logic bias_on;
    } mmw_wake_s;
endpackage

/* mmw_wake_filter.sv */
// Level filter for one wake comparator output
`timescale 1ns/1ps
module mmw_wake_filter #(
    parameter int FILT_CYC = mmw_pkg::WAKE_FILT_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_level,
    output logic o_level
);
    initial begin
        if (FILT_CYC < 1 || FILT_CYC > 65535) $error("FILT_CYC out of range");
    end
    logic sync1;
    logic sync2;
    logic [15:0] cnt;
    logic state;
    logic next_sync1;
    logic next_sync2;
    logic [15:0] next_cnt;
    logic next_state;

    always_comb begin
        next_sync1 = i_level;
        next_sync2 = sync1;
        next_cnt = cnt;
        next_state = state;
        if (sync2 == state) begin
            next_cnt = 16'h0000;
        end else if (cnt == 16'(FILT_CYC - 1)) begin
            next_cnt = 16'h0000;
            next_state = sync2;
        end else begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            cnt <= 16'h0000;
            state <= 1'b0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            cnt <= next_cnt;
            state <= next_state;
        end
    end
    assign o_level = state;

    filt_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (sync2 == state) |=> $stable(state)) else $error("filter changed without input change");
endmodule

/* mmw_top.sv */
// Monitor channel decoder and wake input logic
`timescale 1ns/1ps
module mmw_top #(
    parameter int FILT_CYC = mmw_pkg::WAKE_FILT_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_sel_wr,
    input wire logic [4:0] i_monitor_channel_select,
    input wire logic i_ratio_sel,
    input wire logic i_wake_first_hi,
    input wire logic i_wake_second_hi,
    input wire logic i_wake_first_lo_n,
    input wire logic i_wake_second_lo_n,
    input wire logic i_wake_first_alo_n,
    input wire logic i_wake_second_alo_n,
    input wire logic i_standby,
    output logic [4:0] o_monitor_channel_select,
    output mmw_pkg::mmw_route_s o_route,
    output mmw_pkg::mmw_wake_s o_wake
);
    initial begin
        if (FILT_CYC < 1) $error("FILT_CYC must be positive");
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel select and decode
    logic [4:0] sel;
    logic ratio;
    mmw_pkg::mmw_route_s route;
    logic [4:0] next_sel;
    logic next_ratio;
    mmw_pkg::mmw_route_s next_route;

    function automatic mmw_pkg::mmw_route_s decode(input logic [4:0] s, input logic r);
        mmw_pkg::mmw_route_s d;
        d.src_onehot = '0;
        d.div = mmw_pkg::MMW_DIV_1;
        if (s >= 5'h01 && s <= 5'h06) begin
            d.src_onehot[s] = 1'b1;
        end else if (s >= 5'h07 && s <= 5'h0c) begin
            d.src_onehot[s] = 1'b1;
            d.div = mmw_pkg::MMW_DIV_2P5;
        end else if (s >= 5'h0e && s <= 5'h10) begin
            // Battery and wake share the ratio bit; bridges differ slightly
            d.src_onehot[s] = 1'b1;
            d.div = r ? mmw_pkg::MMW_DIV_HI : mmw_pkg::MMW_DIV_LO;
        end else if (s >= 5'h11 && s <= 5'h14) begin
            d.src_onehot[s] = 1'b1;
        end else begin
            d.src_onehot[0] = 1'b1;
        end
        return d;
    endfunction

    always_comb begin
        next_sel = sel;
        next_ratio = ratio;
        if (i_sel_wr) begin
            next_sel = i_monitor_channel_select;
            next_ratio = i_ratio_sel;
        end
        next_route = decode(next_sel, next_ratio);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sel <= mmw_pkg::SEL_RST;
            ratio <= 1'b0;
            route <= '{src_onehot: 21'h000001, div: mmw_pkg::MMW_DIV_1};
        end else begin
            sel <= next_sel;
            ratio <= next_ratio;
            route <= next_route;
        end
    end
    assign o_monitor_channel_select = sel;
    assign o_route = route;

    ////////////////////////////////////////////////////////////////////////
    // Wake inputs: the high comparator sets, the low comparator clears
    logic first_raw;
    logic second_raw;
    logic next_first_raw;
    logic next_second_raw;
    logic first_filt;
    logic second_filt;

    always_comb begin
        next_first_raw = first_raw;
        next_second_raw = second_raw;
        if (i_wake_first_hi) begin
            next_first_raw = 1'b1;
        end else if (!i_wake_first_lo_n) begin
            next_first_raw = 1'b0;
        end
        if (i_wake_second_hi) begin
            next_second_raw = 1'b1;
        end else if (!i_wake_second_lo_n) begin
            next_second_raw = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            first_raw <= 1'b0;
            second_raw <= 1'b0;
        end else begin
            first_raw <= next_first_raw;
            second_raw <= next_second_raw;
        end
    end

    mmw_wake_filter #(.FILT_CYC(FILT_CYC)) u_filt_first (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(first_raw),
        .o_level(first_filt)
    );
    mmw_wake_filter #(.FILT_CYC(FILT_CYC)) u_filt_second (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(second_raw),
        .o_level(second_filt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bias control and state outputs
    // Bias is left on outside Standby even if both inputs drop, so running rails stay fed
    mmw_pkg::mmw_wake_s wake;
    mmw_pkg::mmw_wake_s next_wake;

    always_comb begin
        next_wake.wake_first = first_filt;
        next_wake.wake_second = second_filt;
        next_wake.bias_on = wake.bias_on;
        if (i_wake_first_hi || i_wake_second_hi) begin
            next_wake.bias_on = 1'b1;
        end else if (!i_wake_first_alo_n && !i_wake_second_alo_n && i_standby) begin
            next_wake.bias_on = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wake <= '0;
        end else begin
            wake <= next_wake;
        end
    end
    assign o_wake = wake;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sel_reset_a: assert property (@(posedge i_sys_clk)
        !i_rst_n |=> sel == 5'h00 && route.src_onehot[0]) else $error("select not ground after reset");
    sel_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sel_wr |=> sel == $past(i_monitor_channel_select)) else $error("select not loaded");
    low_codes_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        sel inside {[5'h01:5'h06]} |-> route.src_onehot[sel] && route.div == mmw_pkg::MMW_DIV_1)
        else $error("undivided code misrouted");
    div_codes_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        sel inside {[5'h07:5'h0c]} |-> route.src_onehot[sel] && route.div == mmw_pkg::MMW_DIV_2P5)
        else $error("divided code misrouted");
    ratio_codes_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        sel inside {[5'h0e:5'h10]} |-> route.src_onehot[sel]
        && route.div == (ratio ? mmw_pkg::MMW_DIV_HI : mmw_pkg::MMW_DIV_LO))
        else $error("ratio code misrouted");
    supply_codes_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        sel inside {[5'h11:5'h14]} |-> route.src_onehot[sel] && $onehot(route.src_onehot))
        else $error("supply code misrouted");
    unused_ground_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (sel == 5'h0d || sel > 5'h14) |-> route.src_onehot == 21'h000001)
        else $error("unassigned code not ground");
    bias_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_wake_first_hi || i_wake_second_hi) |=> wake.bias_on) else $error("bias not started");
    bias_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (wake.bias_on && !i_standby) |=> wake.bias_on) else $error("bias dropped outside standby");
    wake_raw_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (!i_wake_first_hi && !i_wake_first_lo_n) |=> !first_raw) else $error("low wake not zero");
    wake_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 wake.wake_first == $past(first_filt)) else $error("wake state not forwarded");
endmodule

/* mmw_wake_src.sv */
// Model of the two wake sources and their threshold comparators
`timescale 1ns/1ps
module mmw_wake_src (
    input wire logic [7:0] i_first_dv,
    input wire logic [7:0] i_second_dv,
    output logic o_first_hi,
    output logic o_second_hi,
    output logic o_first_lo_n,
    output logic o_second_lo_n,
    output logic o_first_alo_n,
    output logic o_second_alo_n
);
    // Pin levels in tenths of a volt; thresholds at the guaranteed limits
    localparam logic [7:0] HI_DV = 8'h28;
    localparam logic [7:0] LO_DV = 8'h14;
    localparam logic [7:0] ALO_DV = 8'h0a;
    assign o_first_hi = i_first_dv > HI_DV;
    assign o_second_hi = i_second_dv > HI_DV;
    assign o_first_lo_n = !(i_first_dv < LO_DV);
    assign o_second_lo_n = !(i_second_dv < LO_DV);
    assign o_first_alo_n = !(i_first_dv < ALO_DV);
    assign o_second_alo_n = !(i_second_dv < ALO_DV);
endmodule

/* tb.sv */
// Self-checking bench for the monitor select and wake block
`timescale 1ns/1ps
module tb;
    logic i_sys_clk = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_sel_wr = 1'h0;
    logic [4:0] sel = 5'h00;
    logic ratio = 1'h0;
    logic i_standby = 1'h0;
    logic [7:0] v1 = 8'h00;
    logic [7:0] v2 = 8'h00;
    logic h1, h2, l1, l2, a1, a2, wr_q;
    logic [4:0] o_monitor_channel_select;
    mmw_pkg::mmw_route_s o_route;
    mmw_pkg::mmw_wake_s o_wake;
    logic [27:0] exp_q[$];
    int errors = 0;
    int check_count = 0;
    always #50 i_sys_clk = ~i_sys_clk;
    // Short filter keeps the wake runs brief
    mmw_top #(.FILT_CYC(5)) uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sel_wr(i_sel_wr),
        .i_monitor_channel_select(sel), .i_ratio_sel(ratio), .i_wake_first_hi(h1), .i_wake_second_hi(h2),
        .i_wake_first_lo_n(l1), .i_wake_second_lo_n(l2), .i_wake_first_alo_n(a1), .i_wake_second_alo_n(a2),
        .i_standby(i_standby), .o_monitor_channel_select(o_monitor_channel_select), .o_route(o_route),
        .o_wake(o_wake));
    mmw_wake_src src (.i_first_dv(v1), .i_second_dv(v2), .o_first_hi(h1), .o_second_hi(h2),
        .o_first_lo_n(l1), .o_second_lo_n(l2), .o_first_alo_n(a1), .o_second_alo_n(a2));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic mmw_pkg::mmw_route_s exp_route(input logic [4:0] c, input logic r);
        mmw_pkg::mmw_route_s e;
        e.src_onehot = '0;
        e.div = mmw_pkg::MMW_DIV_1;
        if (c > 5'h14 || c == 5'h0d) e.src_onehot[0] = 1'h1;
        else e.src_onehot[c] = 1'h1;
        if (c >= 5'h07 && c <= 5'h0c) e.div = mmw_pkg::MMW_DIV_2P5;
        if (c >= 5'h0e && c <= 5'h10) e.div = r ? mmw_pkg::MMW_DIV_HI : mmw_pkg::MMW_DIV_LO;
        return e;
    endfunction
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic write_sel(input logic [4:0] c, input logic r);
        @(posedge i_sys_clk);
        i_sel_wr <= 1'h1;
        sel <= c;
        ratio <= r;
        exp_q.push_back({c, exp_route(c, r)});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // Bounded wait on one bit of the wake struct: 2 first, 1 second, 0 bias
    task automatic wait_wake(input int b, input logic v, input int n);
        for (int k = 0; k < n && o_wake[b] !== v; k++) @(negedge i_sys_clk);
        check("wake", 32'(o_wake[b]), 32'(v));
        if (o_wake[b] !== v) complete_run();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_sys_clk) wr_q <= i_sel_wr;
    always @(negedge i_sys_clk) begin
        if (wr_q === 1'h1 && exp_q.size() > 0) begin
            logic [27:0] e;
            e = exp_q.pop_front();
            check("select", 32'(o_monitor_channel_select), 32'(e[27:23]));
            check("route", 32'(o_route), 32'(e[22:0]));
        end
    end
    initial begin
        void'($urandom(32'h06c42e4b));
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'h1;
        idle(1);
        check("reset route", 32'(o_route), 32'(exp_route(5'h00, 1'h0)));
        check("reset wake", 32'(o_wake), 32'h0);
        // Every code with both ratio values, back to back, then random codes
        for (int r = 0; r < 2; r++) for (int c = 0; c < 32; c++) write_sel(5'(c), 1'(r));
        repeat (20) write_sel(5'($urandom), 1'($urandom));
        @(posedge i_sys_clk);
        i_sel_wr <= 1'h0;
        idle(3);
        check("queue", 32'(exp_q.size()), 32'h0);
        // A pulse shorter than the filter must not reach the filtered state
        @(posedge i_sys_clk) v1 <= 8'h32;
        repeat (3) @(posedge i_sys_clk);
        // Drop below the low threshold, or the raw latch would hold the pulse by hysteresis
        v1 <= 8'h0f;
        idle(15);
        check("short pulse", 32'(o_wake[2]), 32'h0);
        check("bias start", 32'(o_wake[0]), 32'h1);
        @(posedge i_sys_clk) v1 <= 8'h32;
        idle(3);
        check("sync delay", 32'(o_wake[2]), 32'h0);
        wait_wake(2, 1'h1, 20);
        @(posedge i_sys_clk) v1 <= 8'h1e;
        idle(15);
        check("hysteresis", 32'(o_wake[2]), 32'h1);
        @(posedge i_sys_clk) v1 <= 8'h0f;
        wait_wake(2, 1'h0, 20);
        @(posedge i_sys_clk) i_standby <= 1'h1;
        idle(10);
        check("bias above alo", 32'(o_wake[0]), 32'h1);
        @(posedge i_sys_clk) begin
            i_standby <= 1'h0;
            v2 <= 8'h32;
        end
        wait_wake(1, 1'h1, 20);
        @(posedge i_sys_clk) begin
            v1 <= 8'h05;
            v2 <= 8'h05;
        end
        wait_wake(1, 1'h0, 20);
        check("bias not standby", 32'(o_wake[0]), 32'h1);
        @(posedge i_sys_clk) i_standby <= 1'h1;
        wait_wake(0, 1'h0, 10);
        // A second reset in mid-run returns the select to ground
        write_sel(5'h0e, 1'h1);
        @(posedge i_sys_clk) i_sel_wr <= 1'h0;
        @(posedge i_sys_clk) i_rst_n <= 1'h0;
        @(posedge i_sys_clk) i_rst_n <= 1'h1;
        idle(1);
        check("rerun select", 32'(o_monitor_channel_select), 32'h0);
        complete_run();
    end
endmodule
